// ===== tb/sal_link_props.sv
// concurrent checks on the converter link wires
`timescale 1ns/1ps
module sal_link_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // link wires
  input wire logic convert_start,
  input wire logic readout_clk,
  input wire logic echoed_clock_out,
  input wire logic data_lane_a,
  input wire logic data_lane_b,
  input wire logic power_down_n,
  input wire logic dual_lane_select,
  input wire logic pattern_force
);
  import sal_pkg::*;
  logic [2:0] up_q;
  logic [3:0] pulse_q;
  logic [5:0] since_q;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // cycles the device has been powered, saturating
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      up_q <= 3'h0;
    else if (!power_down_n)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  // readout pulses since the last convert start
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pulse_q <= 4'h0;
    else if ($rose(convert_start))
      pulse_q <= 4'h0;
    else if ($rose(readout_clk))
      pulse_q <= pulse_q + 4'h1;
  end
  // cycles since the last convert start, saturating
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      since_q <= 6'h3F;
    else if ($rose(convert_start))
      since_q <= 6'h00;
    else if (since_q != 6'h3F)
      since_q <= since_q + 6'h01;
  end
  sequence cnv_hold_s;
    convert_start [*2] ##1 !convert_start;
  endsequence
  sequence clk_pulse_s;
    readout_clk ##1 !readout_clk;
  endsequence
  echo_follow_a: assert property (up_q >= 3'h5 |-> echoed_clock_out == readout_clk)
    else $error("echoed clock differs from readout clock");
  pd_quiet_a: assert property (!power_down_n [*5] |-> !data_lane_a && !data_lane_b && !echoed_clock_out)
    else $error("outputs active while powered down");
  lane_b_off_a: assert property (!dual_lane_select [*5] |-> !data_lane_b)
    else $error("lane b active in single lane mode");
  burst_len_a: assert property ($rose(readout_clk) |-> pulse_q < (dual_lane_select ? PULSES_DUAL : PULSES_SINGLE))
    else $error("too many readout pulses in a burst");
  msb_first_a: assert property ($rose(readout_clk) && pulse_q == 4'h0 && pattern_force
    |-> $past(data_lane_a) && (!dual_lane_select || $past(data_lane_b)))
    else $error("pattern msb not shown before first edge");
  cnv_high_a: assert property ($rose(convert_start) |-> cnv_hold_s)
    else $error("convert high time wrong");
  cnv_space_a: assert property ($rose(convert_start) |-> since_q >= CNV_PERIOD_CYC - 1)
    else $error("convert starts too close");
  half_period_a: assert property ($rose(readout_clk) |-> clk_pulse_s)
    else $error("readout clock half period wrong");
  burst_wait_a: assert property ($rose(convert_start) |-> !readout_clk [*7])
    else $error("readout burst before conversion end");
endmodule

// ===== tb/tb_sar_adc_conversion_lvds_readout.sv
// self-checking bench: controller and converter joined over the link
`timescale 1ns/1ps
module tb_sar_adc_conversion_lvds_readout;
  import sal_pkg::*;
  localparam int REC = 20;
  logic core_clk = 1'b0;
  logic rstn, start, pd_req, dual, pat, mon_dual;
  logic ready, res_valid, busy, powered, busy2, powered2;
  logic [15:0] code;
  logic [15:0] result;
  logic [15:0] sh;
  int edges;
  int n_fail = 0;
  int num_checks = 0;
  sal_link_if link();
  sal_link_if link2();
  always #10 core_clk = ~core_clk;
  sal_ctl #(.RECOVER_CYC(REC)) sal_ctl_i (.core_clk_i(core_clk), .rstn_i(rstn), .start_i(start),
    .power_down_req_i(pd_req), .dual_lane_i(dual), .pattern_i(pat), .ready_o(ready), .result_o(result),
    .result_valid_o(res_valid), .link(link));
  sal_dev sal_dev_i (.core_clk_i(core_clk), .rstn_i(rstn), .analog_code_i(code), .busy_o(busy),
    .powered_o(powered), .link(link));
  // second converter driven straight by the bench
  sal_dev sal_dev_far_i (.core_clk_i(core_clk), .rstn_i(rstn), .analog_code_i(code), .busy_o(busy2),
    .powered_o(powered2), .link(link2));
  sal_link_props sal_link_props_i (.core_clk_i(core_clk), .rstn_i(rstn), .convert_start(link.convert_start),
    .readout_clk(link.readout_clk), .echoed_clock_out(link.echoed_clock_out), .data_lane_a(link.data_lane_a),
    .data_lane_b(link.data_lane_b), .power_down_n(link.power_down_n), .dual_lane_select(link.dual_lane_select),
    .pattern_force(link.pattern_force));
  // capture the pre-edge lane values on every echoed edge
  always @(link.echoed_clock_out)
  begin
    edges = edges + 1;
    sh = mon_dual ? {sh[13:0], link.data_lane_a, link.data_lane_b} : {sh[14:0], link.data_lane_a};
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
  begin
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task automatic final_report;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task automatic run_one(input logic d, input logic p, input logic [15:0] c, input logic want, input logic [15:0] exp);
    int i;
    int nb;
    logic seen;
  begin
    seen = 1'b0;
    nb = 0;
    for (i = 0; i < 200 && ready !== 1'b1; i++)
      @(negedge core_clk);
    dual = d;
    pat = p;
    code = c;
    mon_dual = d;
    edges = 0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    for (i = 0; i < 80 && !seen; i++)
    begin
      @(negedge core_clk);
      seen = (res_valid === 1'b1);
      nb += (busy === 1'b1);
    end
    check("valid pulse", {15'h0, want}, {15'h0, seen});
    check("conversion span", 16'h1, {15'h0, nb > 0 && nb <= CONV_CYC});
    check("result", exp, result);
    check("wire word", exp, sh);
    check("echo edges", d ? 16'(2 * PULSES_DUAL) : 16'(2 * PULSES_SINGLE), 16'(edges));
  end
  endtask
  task automatic t_warmup;
  begin
    run_one(1'b0, 1'b0, 16'h1357, 1'b0, INVALID_WORD);
    run_one(1'b0, 1'b0, 16'h1357, 1'b0, INVALID_WORD);
    run_one(1'b0, 1'b0, 16'h1357, 1'b1, 16'h1357);
  end
  endtask
  task automatic t_single;
  begin
    run_one(1'b0, 1'b0, 16'h9A5C, 1'b1, 16'h9A5C);
    run_one(1'b0, 1'b0, 16'h8001, 1'b1, 16'h8001);
  end
  endtask
  task automatic t_dual;
  begin
    run_one(1'b1, 1'b0, 16'h5AC3, 1'b1, 16'h5AC3);
    run_one(1'b1, 1'b0, 16'hFFFE, 1'b1, 16'hFFFE);
  end
  endtask
  task automatic t_pattern;
  begin
    run_one(1'b0, 1'b1, 16'h1234, 1'b1, PAT_SINGLE);
    run_one(1'b1, 1'b1, 16'h1234, 1'b1, PAT_DUAL);
    run_one(1'b0, 1'b0, 16'h1234, 1'b1, 16'h1234);
  end
  endtask
  task automatic t_powerdown;
    int n;
  begin
    pd_req = 1'b1;
    repeat (10) @(negedge core_clk);
    check("powered", 16'h0, {15'h0, powered});
    check("lanes off", 16'h0, {14'h0, link.data_lane_a, link.data_lane_b});
    pd_req = 1'b0;
    n = 0;
    for (int i = 0; i < 200 && ready !== 1'b1; i++)
    begin
      @(negedge core_clk);
      n++;
    end
    check("recovery wait", 16'h1, {15'h0, n >= REC});
    t_warmup();
  end
  endtask
  task automatic t_far;
    int nb;
  begin
    code = 16'hC0DE;
    for (int k = 0; k < 4; k++)
    begin
      if (k == 1)
        link2.power_down_n = 1'b1;
      repeat (6) @(negedge core_clk);
      link2.convert_start = 1'b1;
      repeat (2) @(negedge core_clk);
      link2.convert_start = 1'b0;
      nb = 0;
      repeat (14)
        @(negedge core_clk) nb += (busy2 === 1'b1);
      if (k == 0)
        check("ignored convert", 16'h0, 16'(nb));
      else
        check("busy span", 16'h1, {15'h0, nb > 0 && nb <= CONV_CYC});
    end
    check("first bit", 16'h1, {15'h0, link2.data_lane_a});
    check("far powered", 16'h1, {15'h0, powered2});
  end
  endtask
  initial
  begin
    rstn = 1'b0;
    start = 1'b0;
    pd_req = 1'b0;
    dual = 1'b0;
    pat = 1'b0;
    mon_dual = 1'b0;
    code = 16'h0000;
    sh = 16'h0000;
    edges = 0;
    link2.convert_start = 1'b0;
    link2.readout_clk = 1'b0;
    link2.power_down_n = 1'b0;
    link2.dual_lane_select = 1'b0;
    link2.pattern_force = 1'b0;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    t_warmup();
    t_single();
    t_dual();
    t_pattern();
    t_powerdown();
    t_far();
    final_report();
  end
  // watchdog sized well above the expected run of about seven hundred cycles
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule

// ===== verilog/sal_ctl.sv
// controller end: starts conversions, bursts the readout clock, captures results
`timescale 1ns/1ps
module sal_ctl #(
  parameter int RECOVER_CYC = sal_pkg::PD_RECOVER_CYC,
  parameter int HIGH_CYC = sal_pkg::CNV_HIGH_CYC,
  parameter int PERIOD_CYC = sal_pkg::CNV_PERIOD_CYC,
  parameter int WAIT_CYC = sal_pkg::CONV_WAIT_CYC,
  parameter int HALF_CYC = sal_pkg::HALF_PER_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // user side
  input wire logic start_i,
  input wire logic power_down_req_i,
  input wire logic dual_lane_i,
  input wire logic pattern_i,
  output logic ready_o,
  output logic [sal_pkg::RES_W-1:0] result_o,
  output logic result_valid_o,
  // link
  sal_link_if.ctl link
);
  import sal_pkg::*;

  initial
  begin
    if (RECOVER_CYC < 1 || RECOVER_CYC > 1048575 || HIGH_CYC < 1 || HALF_CYC < 1 || HALF_CYC > 255
        || PERIOD_CYC <= HIGH_CYC || PERIOD_CYC > 255 || WAIT_CYC <= HIGH_CYC || WAIT_CYC > 255)
      $error("sal_ctl: unsupported timing parameters");
  end

  typedef enum logic [2:0] {
    SC_IDLE = 3'b000, SC_HIGH = 3'b001, SC_CONV = 3'b011,
    SC_BURST = 3'b010, SC_GRAB = 3'b110, SC_RECOVER = 3'b100
  } sal_cst_t;

  sal_cst_t st_q;
  logic [19:0] tmr_q;
  logic [7:0] per_q;
  logic [7:0] half_q;
  logic [4:0] edges_q;
  logic rclk_q;
  logic cnv_q;
  logic pdn_q;
  logic dual_q;
  logic pat_q;
  logic [1:0] warm_q;
  logic [15:0] cap_pos_q;
  logic [15:0] cap_neg_q;
  logic [15:0] word;

  assign link.convert_start = cnv_q;
  assign link.readout_clk = rclk_q;
  assign link.power_down_n = pdn_q;
  assign link.dual_lane_select = dual_q;
  assign link.pattern_force = pat_q;
  assign ready_o = (st_q == SC_IDLE) && pdn_q && (per_q == 8'h00);

  // reorders captured bits; registers are stable once the echo clock stops
  always_comb
  begin
    word = 16'h0000;
    for (int k = 0; k < 8; k++)
    begin
      if (!dual_q)
      begin
        word[15-2*k] = cap_pos_q[15-2*k];  // (RULE19)
        word[14-2*k] = cap_neg_q[15-2*k];
      end
      else if (k < 4)
      begin
        word[15-4*k] = cap_pos_q[7-2*k];  // (RULE19)
        word[14-4*k] = cap_pos_q[6-2*k];
        word[13-4*k] = cap_neg_q[7-2*k];
        word[12-4*k] = cap_neg_q[6-2*k];
      end
    end
  end

  // capture on the echoed clock, both edges (RULE12)
  always_ff @(posedge link.echoed_clock_out or negedge rstn_i)
  begin
    if (!rstn_i)
      cap_pos_q <= 16'h0000;
    else
      cap_pos_q <= {cap_pos_q[13:0], link.data_lane_a, link.data_lane_b};
  end

  always_ff @(negedge link.echoed_clock_out or negedge rstn_i)
  begin
    if (!rstn_i)
      cap_neg_q <= 16'h0000;
    else
      cap_neg_q <= {cap_neg_q[13:0], link.data_lane_a, link.data_lane_b};
  end

  // static levels toward the converter
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pdn_q <= 1'b1;
      dual_q <= 1'b0;
      pat_q <= 1'b0;
    end
    else
    begin
      pdn_q <= !power_down_req_i;
      if (st_q == SC_IDLE)
      begin
        dual_q <= dual_lane_i;
        pat_q <= pattern_i;
      end
    end
  end

  // spacing between convert rising edges (RULE7)
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      per_q <= 8'h00;
    else if (st_q == SC_IDLE && start_i && ready_o)
      per_q <= 8'(PERIOD_CYC - 1);
    else if (per_q != 8'h00)
      per_q <= per_q - 8'h01;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q <= SC_IDLE;
      tmr_q <= 20'h00000;
      half_q <= 8'h00;
      edges_q <= 5'h00;
      rclk_q <= 1'b0;
      cnv_q <= 1'b0;
      warm_q <= 2'h0;
      result_o <= RESULT_RST;
      result_valid_o <= 1'b0;
    end
    else
    begin
      result_valid_o <= 1'b0;
      if (!pdn_q)
      begin
        // power-down: link idle, next results are warm-up ones
        st_q <= SC_RECOVER;
        tmr_q <= 20'(RECOVER_CYC - 1);
        cnv_q <= 1'b0;
        rclk_q <= 1'b0;
        warm_q <= 2'h0;  // (RULE6)
      end
      else
      begin
        case (st_q)
          SC_RECOVER:
          begin
            if (tmr_q == 20'h00000)  // (RULE3)
              st_q <= SC_IDLE;
            else
              tmr_q <= tmr_q - 20'h00001;
          end
          SC_IDLE:
          begin
            if (start_i && ready_o)
            begin
              cnv_q <= 1'b1;
              tmr_q <= 20'(HIGH_CYC - 1);
              st_q <= SC_HIGH;
            end
          end
          SC_HIGH:
          begin
            if (tmr_q == 20'h00000)
            begin
              cnv_q <= 1'b0;  // (RULE5)
              tmr_q <= 20'(WAIT_CYC - HIGH_CYC - 1);
              st_q <= SC_CONV;
            end
            else
              tmr_q <= tmr_q - 20'h00001;
          end
          SC_CONV:
          begin
            if (tmr_q == 20'h00000)
            begin
              edges_q <= dual_q ? 5'(2 * PULSES_DUAL) : 5'(2 * PULSES_SINGLE);  // (RULE10) (RULE15)
              half_q <= 8'(HALF_CYC - 1);
              st_q <= SC_BURST;
            end
            else
              tmr_q <= tmr_q - 20'h00001;
          end
          SC_BURST:
          begin
            if (edges_q == 5'h00)
            begin
              tmr_q <= 20'(GRAB_CYC - 1);
              st_q <= SC_GRAB;  // (RULE20)
            end
            else if (half_q == 8'h00)
            begin
              rclk_q <= !rclk_q;
              edges_q <= edges_q - 5'h01;
              half_q <= 8'(HALF_CYC - 1);
            end
            else
              half_q <= half_q - 8'h01;
          end
          SC_GRAB:
          begin
            if (tmr_q == 20'h00000)
            begin
              result_o <= word;
              if (warm_q == 2'(WARMUP_CONV))
                result_valid_o <= 1'b1;
              else
                warm_q <= warm_q + 2'h1;  // (RULE6)
              st_q <= SC_IDLE;  // (RULE13)
            end
            else
              tmr_q <= tmr_q - 20'h00001;
          end
          default:
            st_q <= SC_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== verilog/sal_dev.sv
// converter end: conversion control and double-data-rate serial readout
// Operation
// (RULE1) reset at power-up, reinitialise on supply return
// (RULE2) power-down stops everything, converts ignored
// (RULE3) controller waits 20 ms after power-down release
// (RULE4) convert rising edge samples and starts conversion
// (RULE5) controller keeps convert high and low minimums
// (RULE6) first two results after power-up are discarded
// (RULE7) convert edges spaced by the conversion period
// (RULE8) conversion finishes within 78 ns
// (RULE9) lane a shows msb before first edge
// (RULE10) single lane: eight readout pulses per result
// (RULE11) lanes advance on both readout clock edges
// (RULE12) echoed clock aligned to data, used for capture
// (RULE13) readout ends before next conversion finishes
// (RULE14) dual lane select enables lane b, two bits
// (RULE15) dual lane: four readout pulses per result
// (RULE16) pattern force replaces results with fixed pattern
// (RULE17) single lane pattern is A07F, msb first
// (RULE18) dual lane pattern is CC3F across lanes
// (RULE19) sixteen bits msb first, lane a higher
// (RULE20) readout clock idles constant between bursts
`timescale 1ns/1ps
module sal_dev #(
  parameter int CONV_CYCLES = sal_pkg::CONV_CYC
) (
  // internal conversion clock and power-on reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // sampled analog value, same domain as core_clk_i
  input wire logic [sal_pkg::RES_W-1:0] analog_code_i,
  // status toward the user
  output logic busy_o,
  output logic powered_o,
  // link
  sal_link_if.dev link
);
  import sal_pkg::*;

  initial
  begin
    if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
      $error("sal_dev: CONV_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    SD_IDLE = 2'b00,
    SD_CONV = 2'b01
  } sal_dst_t;

  // core domain state
  sal_dst_t st_q;
  logic [7:0] cnt_q;
  logic [15:0] sample_q;
  logic [15:0] result_q;
  logic [15:0] word_q;
  logic [1:0] warm_q;
  logic cnv_meta_q;
  logic cnv_sync_q;
  logic cnv_prev_q;
  logic pd_meta_q;
  logic pd_sync_q;
  logic dual_meta_q;
  logic dual_sync_q;
  logic pat_meta_q;
  logic pat_sync_q;
  logic word_dual_q;
  logic cnv_rise;

  // link domain state
  logic link_rst_n;
  logic [2:0] pos_cnt_q;
  logic [2:0] neg_cnt_q;
  logic [2:0] wrap;
  logic [3:0] edge_idx;
  logic [4:0] shamt;
  logic [15:0] shifted;

  // pins from the controller except readout_clk pass two flip-flops
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnv_meta_q <= 1'b0;
      cnv_sync_q <= 1'b0;
      cnv_prev_q <= 1'b0;
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
      dual_meta_q <= 1'b0;
      dual_sync_q <= 1'b0;
      pat_meta_q <= 1'b0;
      pat_sync_q <= 1'b0;
    end
    else
    begin
      cnv_meta_q <= link.convert_start;
      cnv_sync_q <= cnv_meta_q;
      cnv_prev_q <= cnv_sync_q;
      pd_meta_q <= link.power_down_n;
      pd_sync_q <= pd_meta_q;
      dual_meta_q <= link.dual_lane_select;
      dual_sync_q <= dual_meta_q;
      pat_meta_q <= link.pattern_force;
      pat_sync_q <= pat_meta_q;
    end
  end

  assign cnv_rise = cnv_sync_q && !cnv_prev_q;
  assign busy_o = (st_q == SD_CONV);
  assign powered_o = pd_sync_q;

  // conversion sequencer
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q <= SD_IDLE;  // (RULE1)
      cnt_q <= 8'h00;
      sample_q <= RESULT_RST;
      result_q <= RESULT_RST;
      warm_q <= 2'h0;
    end
    else if (!pd_sync_q)
    begin
      st_q <= SD_IDLE;  // (RULE2)
      cnt_q <= 8'h00;
      result_q <= RESULT_RST;
      warm_q <= 2'h0;  // (RULE6)
    end
    else
    begin
      case (st_q)
        SD_IDLE:
        begin
          if (cnv_rise)
          begin
            sample_q <= analog_code_i;  // (RULE4)
            cnt_q <= 8'(CONV_CYCLES - 1);
            st_q <= SD_CONV;
          end
        end
        SD_CONV:
        begin
          if (cnt_q == 8'h00)
          begin
            // result settles within the conversion time
            st_q <= SD_IDLE;  // (RULE8)
            if (warm_q == 2'(WARMUP_CONV))
              result_q <= sample_q;
            else
            begin
              result_q <= INVALID_WORD;  // (RULE6)
              warm_q <= warm_q + 2'h1;
            end
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        default:
          st_q <= SD_IDLE;
      endcase
    end
  end

  // word offered to the link; only changes at conversion end, mode change or power-down
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      word_q <= RESULT_RST;
    else if (!pd_sync_q)
      word_q <= RESULT_RST;
    else if (pat_sync_q)
      word_q <= dual_sync_q ? PAT_DUAL : PAT_SINGLE;  // (RULE16) (RULE17) (RULE18)
    else
      word_q <= result_q;
  end

  // lane mode travels with the word; the readout clock only runs in bursts, so it cannot synchronise a level
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      word_dual_q <= 1'b0;
    else if (!pd_sync_q)
      word_dual_q <= 1'b0;
    else
      word_dual_q <= dual_sync_q;
  end

  // link logic is held in reset while powered down
  assign link_rst_n = rstn_i && pd_sync_q;

  // a burst of full pulses brings both counters back to zero
  assign wrap = word_dual_q ? 3'(PULSES_DUAL - 1) : 3'(PULSES_SINGLE - 1);  // (RULE10) (RULE15)

  always_ff @(posedge link.readout_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      pos_cnt_q <= 3'h0;
    else if (pos_cnt_q == wrap)
      pos_cnt_q <= 3'h0;  // (RULE20)
    else
      pos_cnt_q <= pos_cnt_q + 3'h1;  // (RULE11)
  end

  always_ff @(negedge link.readout_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      neg_cnt_q <= 3'h0;
    else if (neg_cnt_q == wrap)
      neg_cnt_q <= 3'h0;
    else
      neg_cnt_q <= neg_cnt_q + 3'h1;  // (RULE11)
  end

  // bit selection: index zero presents the msb before any edge
  // the rising counter wraps one edge before the falling one; add the burst back until that edge
  assign edge_idx = {1'b0, pos_cnt_q} + {1'b0, neg_cnt_q} + ((pos_cnt_q < neg_cnt_q) ? ({1'b0, wrap} + 4'h1) : 4'h0);
  assign shamt = word_dual_q ? {edge_idx, 1'b0} : {1'b0, edge_idx};  // (RULE14)
  assign shifted = word_q << shamt;

  assign link.data_lane_a = pd_sync_q && shifted[15];  // (RULE9) (RULE19)
  assign link.data_lane_b = pd_sync_q && word_dual_q && shifted[14];  // (RULE14)
  assign link.echoed_clock_out = pd_sync_q && link.readout_clk;  // (RULE12)
endmodule

// ===== verilog/sal_link_if.sv
// link wires between the converter and its controller
`timescale 1ns/1ps
interface sal_link_if;
  logic convert_start;
  logic readout_clk;
  logic echoed_clock_out;
  logic data_lane_a;
  logic data_lane_b;
  logic power_down_n;
  logic dual_lane_select;
  logic pattern_force;
  modport dev (
    input convert_start,
    input readout_clk,
    input power_down_n,
    input dual_lane_select,
    input pattern_force,
    output echoed_clock_out,
    output data_lane_a,
    output data_lane_b
  );
  modport ctl (
    output convert_start,
    output readout_clk,
    output power_down_n,
    output dual_lane_select,
    output pattern_force,
    input echoed_clock_out,
    input data_lane_a,
    input data_lane_b
  );
endinterface

// ===== verilog/sal_pkg.sv
// shared constants for the sar adc conversion and serial readout link
package sal_pkg;
  localparam int RES_W = 16;
  localparam int CLK_PERIOD_NS = 20;
  // conversion time is a longest time: rounded down, at least one cycle
  localparam int CONV_TIME_NS = 78;
  localparam int CONV_CYC_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int ACQ_TIME_NS = 50;
  // recovery after power-down is a least time: rounded up
  localparam int PD_RECOVER_MS = 20;
  localparam int PD_RECOVER_CYC = (PD_RECOVER_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARMUP_CONV = 2;
  localparam int PULSES_SINGLE = 8;
  localparam int PULSES_DUAL = 4;
  localparam logic [15:0] PAT_SINGLE = 16'hA07F;
  localparam logic [15:0] PAT_DUAL = 16'hCC3F;
  localparam logic [15:0] INVALID_WORD = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // controller timing defaults in core cycles
  localparam int CNV_HIGH_CYC = 2;
  localparam int CNV_PERIOD_CYC = 16;
  localparam int CONV_WAIT_CYC = 8;
  localparam int GRAB_CYC = 3;
  localparam int HALF_PER_CYC = 1;
endpackage
